// ---- fvi_unit.sv ----
`timescale 1ns/1ps
module fvi_unit (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // Interrupt lines from pins
  input wire logic [fvi_pkg::FVI_LINES-1:0] irq_lines_in,
  // Core side
  input wire logic core_ack_in,
  output logic core_irq_out,
  output logic [7:0] core_vector_out,
  output logic [7:0] spurious_vector_out
);
  import fvi_pkg::*;

  typedef struct packed {
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    logic [31:0] lvl_prev;
    logic [31:0] pending;
    logic [31:0] servicing;
    logic [31:0] trig_level;
    logic [31:0] masked;
    logic [5:0] threshold;
    logic [7:0] spurious;
    logic [31:0] tmr_ctrl;
    logic [31:0] tmr_init;
    logic [31:0] tmr_cur;
    logic [31:0] index;
    logic [31:0] rdata;
    logic irq;
    logic [7:0] vector;
  } fvi_state_type;

  fvi_state_type st_ff;
  fvi_state_type nxt_st;

  function automatic logic [5:0] fvi_top(input logic [31:0] bits);
    logic [5:0] r;
    r = 6'h3f;
    for (int i = 0; i < FVI_LINES; i++) begin
      if (bits[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // One-hot mask for a line index
  function automatic logic [31:0] fvi_onehot(input logic [4:0] idx);
    logic [31:0] r;
    r = 32'h0;
    r[idx] = 1'b1;
    return r;
  endfunction

  logic [31:0] line_now;
  logic [31:0] line_rise;
  logic [31:0] accept;
  logic [4:0] win_line;
  logic [5:0] top_pend;
  logic [5:0] top_serv;
  logic [5:0] floor;
  logic [5:0] eff_prio;
  logic [31:0] tmr_hit;
  logic tmr_expire;
  logic [31:0] ack_set;
  logic [31:0] done_clr;

  always_comb begin
    nxt_st = st_ff;
    // Three-stage sync; a change counts when stages two and three agree
    nxt_st.s1 = irq_lines_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    line_now = st_ff.lvl_prev;
    for (int i = 0; i < FVI_LINES; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        line_now[i] = st_ff.s3[i];
      end
    end
    nxt_st.lvl_prev = line_now;
    line_rise = line_now & ~st_ff.lvl_prev;
    win_line = {st_ff.index[6:5], st_ff.index[3:1]};

    // Timer
    tmr_expire = 1'b0;
    if (st_ff.tmr_cur != 32'h0) begin
      if (st_ff.tmr_cur == 32'h1) begin
        tmr_expire = 1'b1;
        if (st_ff.tmr_ctrl[FVI_TMR_PERIODIC_BIT]) begin
          nxt_st.tmr_cur = st_ff.tmr_init;
        end else begin
          nxt_st.tmr_cur = 32'h0;
        end
      end else begin
        nxt_st.tmr_cur = st_ff.tmr_cur - 32'h1;
      end
    end
    tmr_hit = 32'h0;
    if (tmr_expire && !st_ff.tmr_ctrl[FVI_TMR_MASK_BIT]) begin
      tmr_hit = fvi_onehot({1'b0, st_ff.tmr_ctrl[FVI_TMR_LINE_LSB +: FVI_TMR_LINE_W]});
    end

    // Acceptance: masked lines dropped, edge on rise, level while high
    accept = ((line_rise & ~st_ff.trig_level) | (line_now & st_ff.trig_level) | tmr_hit)
      & ~st_ff.masked;

    // Priority resolution
    top_pend = fvi_top(st_ff.pending);
    top_serv = fvi_top(st_ff.servicing);
    floor = st_ff.threshold;
    if (top_serv != 6'h3f && (top_serv + 6'h1) > floor) begin
      floor = top_serv + 6'h1;
    end
    eff_prio = st_ff.threshold;
    if (top_serv != 6'h3f && top_serv > st_ff.threshold) begin
      eff_prio = top_serv;
    end
    nxt_st.irq = (top_pend != 6'h3f) && (top_pend >= floor)
      && (st_ff.threshold < FVI_THRESHOLD_ALL_OFF);
    nxt_st.vector = FVI_VECTOR_BASE + {2'b00, top_pend};

    // Acknowledge moves the highest pending to servicing
    ack_set = 32'h0;
    if (core_ack_in && top_pend != 6'h3f) begin
      ack_set = fvi_onehot(top_pend[4:0]);
    end
    done_clr = 32'h0;
    if (reg_wr_in && reg_addr_in == FVI_ADDR_DONE && top_serv != 6'h3f) begin
      done_clr = fvi_onehot(top_serv[4:0]);
    end
    // Clear then set so a new request wins; a line still high stays pending
    nxt_st.pending = (st_ff.pending & ~(ack_set & ~line_now)) | accept;
    nxt_st.servicing = (st_ff.servicing & ~done_clr) | ack_set;

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        FVI_ADDR_THRESHOLD: begin
          nxt_st.threshold = (reg_wdata_in[7:0] > 8'h20) ? FVI_THRESHOLD_ALL_OFF
            : reg_wdata_in[5:0];
        end
        FVI_ADDR_SPURIOUS: begin
          nxt_st.spurious = reg_wdata_in[7:0];
        end
        FVI_ADDR_TIMER_CTRL: begin
          nxt_st.tmr_ctrl = reg_wdata_in;
        end
        FVI_ADDR_TIMER_INIT: begin
          nxt_st.tmr_init = reg_wdata_in;
          nxt_st.tmr_cur = reg_wdata_in;
        end
        FVI_ADDR_CFG_INDEX: begin
          nxt_st.index = reg_wdata_in & FVI_INDEX_KEEP;
        end
        FVI_ADDR_CFG_WINDOW: begin
          nxt_st.trig_level[win_line] = reg_wdata_in[FVI_WIN_TRIGGER_BIT];
          nxt_st.masked[win_line] = reg_wdata_in[FVI_WIN_MASK_BIT];
        end
        default: begin
        end
      endcase
    end

    // Register reads, registered one cycle later
    nxt_st.rdata = 32'h0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        FVI_ADDR_THRESHOLD: begin
          nxt_st.rdata = {26'h0, st_ff.threshold};
        end
        FVI_ADDR_EFF_PRIO: begin
          nxt_st.rdata = {26'h0, eff_prio};
        end
        FVI_ADDR_SPURIOUS: begin
          nxt_st.rdata = {24'h0, st_ff.spurious};
        end
        FVI_ADDR_SERVICING: begin
          nxt_st.rdata = st_ff.servicing;
        end
        FVI_ADDR_PENDING: begin
          nxt_st.rdata = st_ff.pending;
        end
        FVI_ADDR_TIMER_CTRL: begin
          nxt_st.rdata = st_ff.tmr_ctrl;
        end
        FVI_ADDR_TIMER_INIT: begin
          nxt_st.rdata = st_ff.tmr_init;
        end
        FVI_ADDR_TIMER_CUR: begin
          nxt_st.rdata = st_ff.tmr_cur;
        end
        FVI_ADDR_CFG_INDEX: begin
          nxt_st.rdata = st_ff.index;
        end
        FVI_ADDR_CFG_WINDOW: begin
          nxt_st.rdata[FVI_WIN_TRIGGER_BIT] = st_ff.trig_level[win_line];
          nxt_st.rdata[FVI_WIN_MASK_BIT] = st_ff.masked[win_line];
        end
        default: begin
          nxt_st.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_ff.s1 <= 32'h0;
      st_ff.s2 <= 32'h0;
      st_ff.s3 <= 32'h0;
      st_ff.lvl_prev <= 32'h0;
      st_ff.pending <= 32'h0;
      st_ff.servicing <= 32'h0;
      st_ff.trig_level <= 32'h0;
      st_ff.masked <= 32'h0;
      st_ff.threshold <= FVI_THRESHOLD_RESET;
      st_ff.spurious <= FVI_SPURIOUS_RESET;
      st_ff.tmr_ctrl <= 32'h0;
      st_ff.tmr_init <= 32'h0;
      st_ff.tmr_cur <= 32'h0;
      st_ff.index <= 32'h0;
      st_ff.rdata <= 32'h0;
      st_ff.irq <= 1'b0;
      st_ff.vector <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out = st_ff.rdata;
  assign core_irq_out = st_ff.irq;
  assign core_vector_out = st_ff.vector;
  assign spurious_vector_out = st_ff.spurious;
endmodule

// ---- fvi_pkg.sv ----
package fvi_pkg;
  localparam int FVI_LINES = 32;
  localparam logic [31:0] FVI_ADDR_THRESHOLD = 32'hfee00080;
  localparam logic [31:0] FVI_ADDR_EFF_PRIO = 32'hfee000a0;
  localparam logic [31:0] FVI_ADDR_DONE = 32'hfee000b0;
  localparam logic [31:0] FVI_ADDR_SPURIOUS = 32'hfee000f0;
  localparam logic [31:0] FVI_ADDR_SERVICING = 32'hfee00110;
  localparam logic [31:0] FVI_ADDR_PENDING = 32'hfee00210;
  localparam logic [31:0] FVI_ADDR_TIMER_CTRL = 32'hfee00320;
  localparam logic [31:0] FVI_ADDR_TIMER_INIT = 32'hfee00380;
  localparam logic [31:0] FVI_ADDR_TIMER_CUR = 32'hfee00390;
  localparam logic [31:0] FVI_ADDR_CFG_INDEX = 32'hfec00000;
  localparam logic [31:0] FVI_ADDR_CFG_WINDOW = 32'hfec00010;
  localparam logic [7:0] FVI_VECTOR_BASE = 8'h20;
  localparam logic [5:0] FVI_THRESHOLD_ALL_OFF = 6'h20;
  localparam int FVI_TMR_LINE_LSB = 0;
  localparam int FVI_TMR_LINE_W = 4;
  localparam int FVI_TMR_MASK_BIT = 16;
  localparam int FVI_TMR_PERIODIC_BIT = 17;
  localparam int FVI_WIN_TRIGGER_BIT = 15;
  localparam int FVI_WIN_MASK_BIT = 16;
  localparam logic [31:0] FVI_INDEX_KEEP = 32'h0000006e;
  localparam logic [5:0] FVI_THRESHOLD_RESET = 6'h00;
  localparam logic [7:0] FVI_SPURIOUS_RESET = 8'hff;
endpackage

// ---- fvi_monitor.sv ----
`timescale 1ns/1ps
module fvi_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  // Lines and core
  input wire logic [fvi_pkg::FVI_LINES-1:0] irq_lines_in,
  input wire logic core_ack_in,
  input wire logic core_irq_out,
  input wire logic [7:0] core_vector_out,
  input wire logic [7:0] spurious_vector_out
);
  import fvi_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_vector_in_range: assert property (core_irq_out |-> core_vector_out[7:5] == 3'h1)
    else $error("vector outside line range");
  chk_ack_rises_prio: assert property (core_ack_in |-> ##2
    (!core_irq_out || core_vector_out > $past(core_vector_out, 2)))
    else $error("offer after ack not above serviced line");
  chk_offer_holds: assert property (core_irq_out && !core_ack_in && !$past(core_ack_in)
    && !reg_wr_in && !$past(reg_wr_in) |=> core_irq_out && core_vector_out >= $past(core_vector_out))
    else $error("offer dropped or lowered without cause");
  chk_threshold_floor: assert property (reg_wr_in && reg_addr_in == FVI_ADDR_THRESHOLD |-> ##2
    (!core_irq_out || (core_vector_out - 8'h20) >= {2'h0, $past(reg_wdata_in[5:0], 2)}))
    else $error("line below threshold offered");
  chk_spurious_store: assert property (reg_wr_in && reg_addr_in == FVI_ADDR_SPURIOUS |=>
    spurious_vector_out == $past(reg_wdata_in[7:0]))
    else $error("spurious vector not stored");
  chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data without read");
  chk_index_bits: assert property (reg_rd_in && reg_addr_in == FVI_ADDR_CFG_INDEX |=>
    (reg_rdata_out & ~FVI_INDEX_KEEP) == 32'h0)
    else $error("reserved index bits read back");
  chk_prio_width: assert property (reg_rd_in && reg_addr_in == FVI_ADDR_EFF_PRIO |=>
    reg_rdata_out[31:6] == 26'h0)
    else $error("effective priority out of range");
  cov_ack: cover property (core_ack_in);
  cov_threshold: cover property (reg_wr_in && reg_addr_in == FVI_ADDR_THRESHOLD);
  cov_done: cover property (reg_wr_in && reg_addr_in == FVI_ADDR_DONE);
endmodule
bind fvi_unit fvi_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .irq_lines_in(irq_lines_in), .core_ack_in(core_ack_in),
  .core_irq_out(core_irq_out), .core_vector_out(core_vector_out),
  .spurious_vector_out(spurious_vector_out));

// ---- fvi_core_model.sv ----
`timescale 1ns/1ps
module fvi_core_model (
  // Clock, reset, control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic [1:0] lag_in,
  // Controller side
  input wire logic irq_in,
  input wire logic [7:0] vector_in,
  output logic ack_out,
  output logic [7:0] vec_out
);
  logic [2:0] gap_ff;
  logic [1:0] wait_ff;
  always_ff @(posedge clk_in) begin
    ack_out <= 1'b0;
    if (!rst_n_in) begin
      gap_ff <= 3'h0;
      wait_ff <= 2'h0;
      vec_out <= 8'h00;
    end else if (gap_ff != 3'h0) begin
      gap_ff <= gap_ff - 3'h1;
    end else if (go_in && irq_in && wait_ff >= lag_in) begin
      ack_out <= 1'b1;
      vec_out <= vector_in;
      gap_ff <= 3'h3;
      wait_ff <= 2'h0;
    end else begin
      wait_ff <= (go_in && irq_in) ? wait_ff + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import fvi_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [1:0] lag = 2'h0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] lines = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic ack;
  logic irq;
  logic [7:0] vec;
  logic [7:0] spur;
  logic [7:0] taken;
  int n_mismatch = 0;
  int checked = 0;
  always #12.5 clk_in = ~clk_in;
  fvi_unit uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .irq_lines_in(lines),
    .core_ack_in(ack), .core_irq_out(irq), .core_vector_out(vec), .spurious_vector_out(spur));
  fvi_core_model core (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go), .lag_in(lag),
    .irq_in(irq), .vector_in(vec), .ack_out(ack), .vec_out(taken));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr32(input logic [31:0] a, input logic [31:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(input string s, input logic [31:0] a, input logic [31:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    d = rdata;
    chk(s, e, d);
    cyc(1);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(5000);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    cyc(20);
    rst_n_in = 1'b1;
    cyc(4);
    wr32(FVI_ADDR_SPURIOUS, 32'h5a);
    chk("spurious", 32'h5a, {24'h0, spur});
    wr32(FVI_ADDR_CFG_INDEX, 32'hffffffff);
    rchk("index", FVI_ADDR_CFG_INDEX, FVI_INDEX_KEEP);
    rchk("window", FVI_ADDR_CFG_WINDOW, 32'h0);
    go = 1'b1;
    lines[5] = 1'b1;
    cyc(2);
    lines[5] = 1'b0;
    cyc(10);
    chk("vector", 32'h25, {24'h0, taken});
    lines[9] = 1'b1;
    cyc(12);
    chk("preempt", 32'h29, {24'h0, taken});
    rchk("servicing", FVI_ADDR_SERVICING, 32'h220);
    rchk("pending", FVI_ADDR_PENDING, 32'h200);
    rchk("eff prio", FVI_ADDR_EFF_PRIO, 32'h9);
    lines = 32'h0;
    wr32(FVI_ADDR_DONE, 32'hdeadbeef);
    rchk("done", FVI_ADDR_SERVICING, 32'h20);
    wr32(FVI_ADDR_DONE, 32'h0);
    wr32(FVI_ADDR_DONE, 32'h0);
    go = 1'b0;
    lag = 2'h3;
    wr32(FVI_ADDR_THRESHOLD, 32'ha);
    lines[7] = 1'b1;
    cyc(8);
    chk("below floor", 32'h0, {31'h0, irq});
    rchk("held", FVI_ADDR_PENDING, 32'h80);
    wr32(FVI_ADDR_THRESHOLD, 32'h20);
    lines[20] = 1'b1;
    cyc(8);
    chk("blocked", 32'h0, {31'h0, irq});
    lines = 32'h0;
    wr32(FVI_ADDR_THRESHOLD, 32'h0);
    go = 1'b1;
    cyc(12);
    chk("highest", 32'h34, {24'h0, taken});
    wr32(FVI_ADDR_DONE, 32'h0);
    cyc(12);
    chk("next", 32'h27, {24'h0, taken});
    wr32(FVI_ADDR_DONE, 32'h0);
    wr32(FVI_ADDR_CFG_INDEX, 32'h6);
    wr32(FVI_ADDR_CFG_WINDOW, 32'h10000);
    lines[3] = 1'b1;
    cyc(8);
    rchk("masked", FVI_ADDR_PENDING, 32'h0);
    wr32(FVI_ADDR_TIMER_CTRL, 32'h20001);
    wr32(FVI_ADDR_TIMER_INIT, 32'h8);
    cyc(20);
    chk("timer", 32'h21, {24'h0, taken});
    wr32(FVI_ADDR_DONE, 32'h0);
    cyc(12);
    rchk("periodic", FVI_ADDR_SERVICING, 32'h2);
    wr32(FVI_ADDR_TIMER_INIT, 32'h40);
    cyc(4);
    wr32(FVI_ADDR_TIMER_INIT, 32'h80);
    rchk("restart", FVI_ADDR_TIMER_CUR, 32'h7f);
    wr32(FVI_ADDR_TIMER_INIT, 32'h0);
    rchk("stopped", FVI_ADDR_TIMER_CUR, 32'h0);
    rchk("unmapped", 32'hfee00004, 32'h0);
    wr32(FVI_ADDR_TIMER_CTRL, 32'h30002);
    wr32(FVI_ADDR_TIMER_INIT, 32'h4);
    cyc(8);
    rchk("timer mask", FVI_ADDR_PENDING, 32'h2);
    print_verdict;
  end
endmodule
